/* verilog/tcc_defs.svh */
// Constants for the temperature conversion control block.
// Assumes a 125 MHz core clock; counts are in clock cycles.
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH
`define TCC_PTR_CFG_RD     8'h03
`define TCC_PTR_RATE_RD    8'h04
`define TCC_PTR_CFG_WR     8'h09
`define TCC_PTR_RATE_WR    8'h0a
`define TCC_PTR_OFS_HI     8'h11
`define TCC_PTR_OFS_LO     8'h12
`define TCC_PTR_ONESHOT    8'h0f
`define TCC_PTR_NFACT      8'h23
`define TCC_CFG_RESET      8'h00
`define TCC_RATE_RESET     8'h08
`define TCC_RATE_MAX       8'h09
`define TCC_CFG_WMASK      8'he4
`define TCC_BIT_MASK       7
`define TCC_BIT_SD         6
`define TCC_BIT_PINSEL     5
`define TCC_BIT_RANGE      2
`define TCC_CLK_HZ         125000000
`define TCC_NFACT_BASE     2088
// Slowest interval 16 s, in cycles, halved per rate step
`define TCC_IDLE_SLOWEST   64'd2000000000
`endif

/* verilog/tcc_pkg.sv */
// Types for the temperature conversion control block.
// Assumes the constants header is included by its users.
package tcc_pkg;
    typedef enum logic [1:0] {TCC_IDLE, TCC_CONV, TCC_WAIT} tcc_state_t;
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] pointer;
        logic [7:0] wdata;
    } tcc_req_t;
endpackage : tcc_pkg

/* verilog/tcc_core.sv */
// Conversion control: configuration, rate, one-shot, n-factor, offset.
// Assumes a serial engine presents decoded register accesses, one cycle.
// Overview of operation
// [R1] Config written at 09h, read at 03h
// [R2] Mask bit 7 disables alert output
// [R3] Mask ignored when pin select is one
// [R4] Shutdown clear: convert continuously at rate
// [R5] Shutdown set: finish current, then stop
// [R6] Shutdown cleared: resume continuous conversions
// [R7] Bit 5 picks alert or overtemp out
// [R8] Bit 2 picks standard or extended range
// [R9] Host writes zero to reserved bits
// [R10] Rate read 04h, write 0Ah, idle only
// [R11] Codes 0-9 double rate; reset 08h
// [R12] Trigger write in shutdown starts one cycle
// [R13] After triggered cycle return to shutdown
// [R14] Trigger data byte is discarded
// [R15] Signed n-factor adjust at 23h, reset 0
// [R16] Effective factor 1.008*2088/(2088+adjust)
// [R17] Remote offset added to each remote result
// [R18] Offset 12 bits at pointers 11, 12
// [R19] Busy reads one while converting
// [R20] Rate above 09h fastest; ignore trigger running
`timescale 1ns/1ps
`include "tcc_defs.svh"
module tcc_core
(
    // Clock and reset
    input  wire logic            i_clock,
    input  wire logic            i_reset,
    // Decoded register access from the serial engine
    input  wire tcc_pkg::tcc_req_t i_req,
    output logic [7:0]           o_rdata,
    // Measurement path
    input  wire logic            i_conv_done,
    input  wire logic [11:0]     i_remote_raw,
    input  wire logic            i_remote_valid,
    input  wire logic            i_alert_raw,
    input  wire logic            i_overtemp2_raw,
    output logic                 o_conv_start,
    output logic                 o_busy,
    output logic [11:0]          o_remote_result,
    output logic                 o_remote_valid,
    output logic                 o_extended_range,
    output logic signed [7:0]    o_nfactor_adjust,
    output logic [11:0]          o_nfactor_denom,
    // Shared output pin, active low, open drain
    output logic                 o_shared_pin_n
);
    import tcc_pkg::*;

    // ==========================================================
    // Register storage
    // ==========================================================
    logic [7:0]  config_byte;
    logic [7:0]  rate_code;
    logic [7:0]  nfactor;
    logic [11:0] remote_offset;
    tcc_state_t  state;
    logic [63:0] idle_count;
    logic        single_run;

    function automatic logic [63:0] idle_cycles(input logic [7:0] code);
        logic [3:0] c;
        c = (code > `TCC_RATE_MAX) ? 4'(`TCC_RATE_MAX) : code[3:0]; // R20
        idle_cycles = `TCC_IDLE_SLOWEST >> c; // R11
    endfunction : idle_cycles

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            config_byte <= `TCC_CFG_RESET;
        else if (i_req.write && i_req.pointer == `TCC_PTR_CFG_WR)
            config_byte <= i_req.wdata & `TCC_CFG_WMASK; // R1 R9
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            rate_code <= `TCC_RATE_RESET; // R11
        else if (i_req.write && i_req.pointer == `TCC_PTR_RATE_WR)
            rate_code <= i_req.wdata; // R10
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            nfactor <= 8'h00; // R15
        else if (i_req.write && i_req.pointer == `TCC_PTR_NFACT)
            nfactor <= i_req.wdata; // R15
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            remote_offset <= 12'h000;
        else if (i_req.write && i_req.pointer == `TCC_PTR_OFS_HI)
            remote_offset[11:4] <= i_req.wdata; // R18
        else if (i_req.write && i_req.pointer == `TCC_PTR_OFS_LO)
            remote_offset[3:0] <= i_req.wdata[7:4]; // R18
    end

    // ==========================================================
    // Read mux
    // ==========================================================
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            o_rdata <= 8'h00;
        else if (i_req.read)
        begin
            unique case (i_req.pointer)
                `TCC_PTR_CFG_RD:  o_rdata <= config_byte; // R1
                `TCC_PTR_RATE_RD: o_rdata <= rate_code; // R10
                `TCC_PTR_NFACT:   o_rdata <= nfactor;
                `TCC_PTR_OFS_HI:  o_rdata <= remote_offset[11:4];
                `TCC_PTR_OFS_LO:  o_rdata <= {remote_offset[3:0], 4'h0};
                default:          o_rdata <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Conversion sequencer
    // ==========================================================
    logic shutdown;
    logic trigger;
    assign shutdown = config_byte[`TCC_BIT_SD];
    // Data byte of the trigger write is never looked at
    assign trigger  = i_req.write && i_req.pointer == `TCC_PTR_ONESHOT; // R14

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            state        <= TCC_WAIT;
            idle_count   <= 64'h0;
            single_run   <= 1'b0;
            o_conv_start <= 1'b0;
        end
        else
        begin
            o_conv_start <= 1'b0;
            unique case (state)
                TCC_IDLE:
                begin
                    if (!shutdown)
                    begin
                        state      <= TCC_WAIT; // R6
                        idle_count <= 64'h0;
                    end
                    else if (trigger)
                    begin
                        state        <= TCC_CONV; // R12
                        single_run   <= 1'b1;
                        o_conv_start <= 1'b1;
                    end
                end
                TCC_WAIT:
                begin
                    if (shutdown)
                        state <= TCC_IDLE; // R5
                    else if (idle_count >= idle_cycles(rate_code))
                    begin
                        state        <= TCC_CONV; // R4
                        single_run   <= 1'b0;
                        o_conv_start <= 1'b1;
                    end
                    else
                        idle_count <= idle_count + 64'h1; // R10
                end
                TCC_CONV:
                begin
                    // Triggers while running are ignored
                    if (i_conv_done)
                    begin
                        idle_count <= 64'h0;
                        if (shutdown || single_run)
                            state <= TCC_IDLE; // R5 R13 R20
                        else
                            state <= TCC_WAIT; // R4
                    end
                end
            endcase
        end
    end

    assign o_busy = (state == TCC_CONV); // R19

    // ==========================================================
    // Remote correction and pin function
    // ==========================================================
    assign o_nfactor_adjust = nfactor;
    // Denominator of the effective ideality; numerator is 1.008*2088
    assign o_nfactor_denom = 12'(`TCC_NFACT_BASE) + {{4{nfactor[7]}}, nfactor}; // R16
    assign o_extended_range = config_byte[`TCC_BIT_RANGE]; // R8

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            o_remote_result <= 12'h000;
            o_remote_valid  <= 1'b0;
        end
        else
        begin
            o_remote_valid <= i_remote_valid;
            if (i_remote_valid)
                o_remote_result <= i_remote_raw + remote_offset; // R17
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
            o_shared_pin_n <= 1'b1;
        else if (config_byte[`TCC_BIT_PINSEL])
            o_shared_pin_n <= ~i_overtemp2_raw; // R7 R3
        else
            o_shared_pin_n <= ~(i_alert_raw && !config_byte[`TCC_BIT_MASK]); // R2
    end
endmodule : tcc_core

/* tb/tcc_core_props.sv */
// Assertions on the ports of the conversion control core.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module tcc_core_props
(
    // Clock and reset
    input wire logic               i_clock,
    input wire logic               i_reset,
    // Watched ports
    input wire tcc_pkg::tcc_req_t  i_req,
    input wire logic               i_conv_done,
    input wire logic               i_remote_valid,
    input wire logic               o_conv_start,
    input wire logic               o_busy,
    input wire logic               o_remote_valid,
    input wire logic               o_extended_range,
    input wire logic signed [7:0]  o_nfactor_adjust,
    input wire logic [11:0]        o_nfactor_denom,
    input wire logic               o_shared_pin_n
);
    import tcc_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    wire cfg_wr = i_req.write && i_req.pointer == 8'h09;
    wire adj_wr = i_req.write && i_req.pointer == 8'h23;
    sequence s_launch;
        o_conv_start ##0 o_busy;
    endsequence
    a_start_busy: assert property (o_conv_start |-> s_launch)
        else $error("start without busy");
    a_busy_ends: assert property (o_busy && i_conv_done |=> !o_busy)
        else $error("busy after done");
    a_start_once: assert property (o_conv_start |=> !o_conv_start)
        else $error("start longer than one cycle");
    a_range_bit: assert property (cfg_wr |=>
        o_extended_range == $past(i_req.wdata[2]))
        else $error("range bit not applied");
    a_adjust_store: assert property (adj_wr |=>
        o_nfactor_adjust == $past(i_req.wdata))
        else $error("adjust not stored");
    a_denom_sum: assert property (o_nfactor_denom == 12'd2088 +
        {{4{o_nfactor_adjust[7]}}, o_nfactor_adjust})
        else $error("denominator wrong");
    a_offset_valid: assert property (i_remote_valid |=> o_remote_valid)
        else $error("remote result not flagged");
    a_mask_quiet: assert property (cfg_wr && i_req.wdata[7:5] == 3'b100
        |=> ##1 o_shared_pin_n)
        else $error("masked alert drives pin");
    a_sd_stops: assert property (cfg_wr && i_req.wdata[6] && !o_busy
        |=> !o_conv_start[*2])
        else $error("start after shutdown");
endmodule : tcc_core_props
bind tcc_core tcc_core_props i_tcc_core_props (.i_clock(i_clock),
    .i_reset(i_reset), .i_req(i_req), .i_conv_done(i_conv_done),
    .i_remote_valid(i_remote_valid), .o_conv_start(o_conv_start),
    .o_busy(o_busy), .o_remote_valid(o_remote_valid),
    .o_extended_range(o_extended_range),
    .o_nfactor_adjust(o_nfactor_adjust),
    .o_nfactor_denom(o_nfactor_denom), .o_shared_pin_n(o_shared_pin_n));

/* tb/tcc_host_model.sv */
// Bus host model issuing one decoded register access at a time.
// Assumes read data is registered one edge after the request.
`timescale 1ns/1ps
module tcc_host_model
(
    input  wire logic        i_clock,
    input  wire logic [7:0]  i_rdata,
    output tcc_pkg::tcc_req_t o_req
);
    import tcc_pkg::*;
    initial o_req = '0;
    // Request held for one edge, data taken at that edge
    task automatic access(input logic w, input logic [7:0] p, d,
                          output logic [7:0] q);
        @(posedge i_clock);
        #1 o_req = {w, !w, p, d};
        @(posedge i_clock);
        #1 o_req = '0;
        q = i_rdata;
    endtask : access
endmodule : tcc_host_model

/* tb/test_temp_conversion_control.sv */
// Testbench for the conversion control core.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
module test_temp_conversion_control;
    import tcc_pkg::*;
    logic i_clock = 0, i_reset = 1, done = 0, rvalid = 0, alert = 0, ot2 = 0;
    logic [11:0] raw = '0, res, denom;
    logic [7:0] rdata, q, adj;
    logic start, busy, ovalid, ext, pin_n;
    tcc_req_t req;
    int num_errors = 0, samples_checked = 0, cycles = 0, starts = 0, n;
    always #4 i_clock = ~i_clock;
    tcc_host_model i_host (.i_clock(i_clock), .i_rdata(rdata), .o_req(req));
    tcc_core i_tcc_core (.i_clock(i_clock), .i_reset(i_reset), .i_req(req),
        .o_rdata(rdata), .i_conv_done(done), .i_remote_raw(raw),
        .i_remote_valid(rvalid), .i_alert_raw(alert), .i_overtemp2_raw(ot2),
        .o_conv_start(start), .o_busy(busy), .o_remote_result(res),
        .o_remote_valid(ovalid), .o_extended_range(ext),
        .o_nfactor_adjust(adj), .o_nfactor_denom(denom),
        .o_shared_pin_n(pin_n));
    // Measurement path finishes five cycles after each start
    always @(posedge i_clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            complete_run();
        end
        if (start === 1'b1)
        begin
            starts++;
            repeat (5) @(posedge i_clock);
            #1 done = 1;
            @(posedge i_clock);
            #1 done = 0;
        end
    end
    task check(string name, logic [11:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task wr(logic [7:0] p, d);
        i_host.access(1, p, d, q);
    endtask : wr
    task rd(string name, logic [7:0] p, exp);
        i_host.access(0, p, 8'h00, q);
        check(name, {4'h0, q}, {4'h0, exp});
    endtask : rd
    task settle;
        repeat (2) @(posedge i_clock);
        #1;
    endtask : settle
    task t_reset;
        rd("config", 8'h03, 8'h00);
        rd("rate", 8'h04, 8'h08);
        rd("adjust", 8'h23, 8'h00);
    endtask : t_reset
    task t_config;
        ot2 = 1;
        wr(8'h09, 8'hff);
        rd("config", 8'h03, 8'he4);
        rd("write_view", 8'h09, 8'h00);
        check("range", ext, 1'b1);
        check("pin_ot2", pin_n, 1'b0);
        alert = 1;
        wr(8'h09, 8'hc0);
        settle();
        check("pin_mask", pin_n, 1'b1);
        wr(8'h09, 8'h40);
        settle();
        check("pin_alert", pin_n, 1'b0);
        alert = 0;
        ot2 = 0;
    endtask : t_config
    task t_oneshot;
        wr(8'h0a, 8'h05);
        rd("rate", 8'h04, 8'h05);
        n = starts;
        wr(8'h0f, 8'ha5);
        @(posedge i_clock);
        #1 check("busy_on", busy, 1'b1);
        repeat (20) @(posedge i_clock);
        #1 check("busy_off", busy, 1'b0);
        check("one_start", starts, n + 1);
        rd("trigger", 8'h0f, 8'h00);
        wr(8'h09, 8'h00);
        wr(8'h0f, 8'h00);
        repeat (10) @(posedge i_clock);
        check("running", starts, n + 1);
    endtask : t_oneshot
    task t_offset;
        wr(8'h11, 8'h12);
        wr(8'h12, 8'h35);
        rd("offset_hi", 8'h11, 8'h12);
        raw = 12'hf00;
        rvalid = 1;
        @(posedge i_clock);
        #1 rvalid = 0;
        @(posedge i_clock);
        #1 check("remote", res, 12'h023);
        wr(8'h23, 8'h80);
        rd("adjust", 8'h23, 8'h80);
        check("denom", denom, 12'd1960);
    endtask : t_offset
    // Reset in mid-run must restore config, rate, adjust and offset high byte
    task t_reset_again;
        wr(8'h0a, 8'h0c);
        rd("rate_fast", 8'h04, 8'h0c);
        i_reset = 1;
        repeat (2) @(posedge i_clock);
        #1 i_reset = 0;
        check("busy_rst", busy, 1'b0);
        check("pin_rst", pin_n, 1'b1);
        rd("config_rst", 8'h03, 8'h00);
        rd("rate_rst", 8'h04, 8'h08);
        rd("adjust_rst", 8'h23, 8'h00);
        rd("offset_rst", 8'h11, 8'h00);
    endtask : t_reset_again
    task complete_run;
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    initial
    begin
        repeat (12) @(posedge i_clock);
        #1 i_reset = 0;
        t_reset();
        t_config();
        t_oneshot();
        t_offset();
        t_reset_again();
        complete_run();
    end
endmodule : test_temp_conversion_control
